// file: flash_overlay_pkg.sv
// constants, encodings and register map of the overlay space selector
package flash_overlay_pkg;

  // ----------------------------------------
  // link addressing
  // ----------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int SECT_LSB = 16;
  localparam int SECT_W = ADDR_W - SECT_LSB;
  localparam int BURST_WORDS = 32;
  localparam int BURST_LSB_W = 5;
  localparam int LATENCY_CODE = 12;
  localparam int PW_WORDS = 4;
  localparam int PW_IDX_W = 2;
  localparam int WBUF_CNT_W = 5;
  localparam logic [SECT_LSB-1:0] OFS_CMD = 16'h0555;
  localparam logic [ADDR_W-1:0] ADDR_EXIT = 24'h00_0000;
  localparam logic [ADDR_W-1:0] ADDR_CFG = 24'h00_0000;
  localparam logic [DATA_W-1:0] UNDEF_WORD = 16'h0000;

  // ----------------------------------------
  // command codes
  // ----------------------------------------
  localparam logic [DATA_W-1:0] CMD_ID_ENTRY = 16'h0098;
  localparam logic [DATA_W-1:0] CMD_EXIT = 16'h00F0;
  localparam logic [DATA_W-1:0] CMD_LEGACY_EXIT = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_STATUS = 16'h0070;
  localparam logic [DATA_W-1:0] CMD_SECURE_ENTRY = 16'h0088;
  localparam logic [DATA_W-1:0] CMD_PROTCFG_ENTRY = 16'h0040;
  localparam logic [DATA_W-1:0] CMD_PASSWORD_ENTRY = 16'h0060;
  localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00A0;
  localparam logic [DATA_W-1:0] CMD_WBUF = 16'h0025;
  localparam logic [DATA_W-1:0] CMD_UNLOCK = 16'h0029;

  // ----------------------------------------
  // apb register map
  // ----------------------------------------
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] OFS_CRC_LOW = 12'h000;
  localparam logic [APB_AW-1:0] OFS_CRC_HIGH = 12'h004;
  localparam logic [APB_AW-1:0] OFS_CTRL = 12'h008;
  localparam logic [APB_AW-1:0] OFS_STATUS = 12'h00C;
  localparam int CTRL_LINK_EN_BIT = 0;
  localparam int CTRL_LOCK_SET_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] CRC_RESET = 32'h0000_0000;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_LOCK_BIT = 8;
  localparam int ST_SECT_LSB = 16;

  typedef enum logic [5:0] {
    MODE_ARRAY    = 6'h01,
    MODE_IDCFI    = 6'h02,
    MODE_STATUS   = 6'h04,
    MODE_SECURE   = 6'h08,
    MODE_PROTCFG  = 6'h10,
    MODE_PASSWORD = 6'h20
  } mode_e;

  typedef enum logic [5:0] {
    LNK_IDLE  = 6'h01,
    LNK_ADDR  = 6'h02,
    LNK_WDATA = 6'h04,
    LNK_LAT   = 6'h08,
    LNK_BURST = 6'h10,
    LNK_DONE  = 6'h20
  } link_e;

endpackage

// file: flash_overlay_space_select.sv
// address-space overlay selector with check-value register and apb access
// Contract
// - volatile register holds check-value over loaded start..end range
// - check-value split: low word bits 0-15, high word bits 16-31
// - identification entry overlays only the sector given with entry
// - identification entry is word write 0x0098 at offset 0x555
// - identification exit is word write 0x00F0 at address 0x000000
// - status command snapshots status and switches reads to status overlay
// - first read in status overlay restores the previous address map
// - status value only on first burst word, later beats undefined
// - secure entry overlays secure region onto the entry sector
// - overlaid sector reads beyond secure extent return undefined data
// - other sectors read array and do not end secure overlay
// - secure customer area programmable by word or write-buffer program
// - secure overlay exits by legacy exit or common exit
// - config overlay ignores sector, register at word 0, rest undefined
// - config register programmable by modified word program
// - password overlay ignores sector, password at words 0-3
// - password programmable; unlock command then four words matching the password clear global lock bit
// - config and password overlays exit by legacy or common exit
// - 64-byte wrapped burst gives 32 words wrapping, then no data
// - read strobe does not toggle in idle beats
// - software reset returns to array read, outputs untouched; the code decodes no software reset command
module flash_overlay_space_select
  import flash_overlay_pkg::*;
#(
  parameter int SEC_WORDS = 16,
  parameter logic [DATA_W-1:0] PROTCFG_RESET = 16'hFFFF,
  parameter logic [PW_WORDS*DATA_W-1:0] PASSWORD_RESET = 64'hFFFF_FFFF_FFFF_FFFF,
  // identification words: arbitrary values
  parameter logic [PW_WORDS*DATA_W-1:0] ID_WORDS = 64'h0003_0002_0001_0A5A
)(
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [APB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic LINK_CK,
  input wire logic LINK_CS_N,
  input wire logic LINK_WE,
  input wire logic [ADDR_W-1:0] LINK_ADDR,
  input wire logic [DATA_W-1:0] LINK_DQ_I,
  output logic [DATA_W-1:0] LINK_DQ_O,
  output logic LINK_DQ_OE,
  output logic LINK_READ_WRITE_STROBE_O,
  output logic LINK_READ_WRITE_STROBE_OE,
  output logic [ADDR_W-1:0] ARR_ADDR,
  input wire logic [DATA_W-1:0] ARR_RDATA,
  input wire logic [DATA_W-1:0] STAT_IN,
  input wire logic [31:0] CRC_RESULT,
  input wire logic CRC_LOAD,
  output logic GLOBAL_LOCK
);

  localparam int SEC_IDX_W = $clog2(SEC_WORDS);
  localparam int SYNC_W = 3 + ADDR_W + DATA_W;

  // ----------------------------------------
  // link input synchronisers
  // ----------------------------------------
  logic [SYNC_W-1:0] sync1_reg, sync2_reg;
  logic ck_prev_reg;
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
      ck_prev_reg <= 1'b1;
    end else begin
      sync1_reg <= {LINK_CK, LINK_CS_N, LINK_WE, LINK_ADDR, LINK_DQ_I};
      sync2_reg <= sync1_reg;
      ck_prev_reg <= sync2_reg[SYNC_W-1];
    end
  end

  logic ck_s, cs_n_s, we_s, ck_rise;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] dq_s;
  assign {ck_s, cs_n_s, we_s, addr_s, dq_s} = sync2_reg;
  // link clock is slow, so data is long settled at its rising edge
  assign ck_rise = ck_s & ~ck_prev_reg;

  // ----------------------------------------
  // core state
  // ----------------------------------------
  link_e link_reg, link_next;
  mode_e mode_reg, mode_next, prev_mode_reg, prev_mode_next;
  logic [SECT_W-1:0] sect_reg, sect_next;
  logic [ADDR_W-1:0] cap_addr_reg, cap_addr_next, arr_addr_reg, arr_addr_next;
  logic [BURST_LSB_W-1:0] beat_reg, beat_next;
  logic [3:0] lat_reg, lat_next;
  logic stat_serve_reg, stat_serve_next;
  logic [DATA_W-1:0] snap_reg, snap_next, cfg_reg, cfg_next;
  logic [DATA_W-1:0] pw_reg [PW_WORDS];
  logic [DATA_W-1:0] pw_next [PW_WORDS];
  logic [DATA_W-1:0] sec_reg [SEC_WORDS];
  logic [DATA_W-1:0] sec_next [SEC_WORDS];
  logic prog_arm_reg, prog_arm_next, wbuf_cnt_reg, wbuf_cnt_next;
  logic [WBUF_CNT_W:0] wbuf_left_reg, wbuf_left_next;
  logic unlock_act_reg, unlock_act_next, unlock_ok_reg, unlock_ok_next;
  logic [PW_IDX_W-1:0] unlock_idx_reg, unlock_idx_next;
  logic lock_reg, lock_next;
  logic [DATA_W-1:0] dq_reg, dq_next;
  logic dq_oe_reg, dq_oe_next, read_write_strobe_reg, read_write_strobe_next, read_write_strobe_oe_reg, read_write_strobe_oe_next;
  logic [31:0] ctrl_reg, ctrl_next, crc_reg, crc_next, prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;

  logic do_write, cmd_write, read_start, beat_fire, apb_wr;
  logic [ADDR_W-1:0] burst_addr;
  logic [SECT_LSB-1:0] w_ofs, r_ofs;
  logic w_sect_hit, r_sect_hit;
  logic [DATA_W-1:0] rd_word;

  assign burst_addr = {cap_addr_reg[ADDR_W-1:BURST_LSB_W],
                       cap_addr_reg[BURST_LSB_W-1:0] + beat_reg};
  assign w_ofs = cap_addr_reg[SECT_LSB-1:0];
  assign w_sect_hit = (cap_addr_reg[ADDR_W-1:SECT_LSB] == sect_reg);
  assign r_ofs = burst_addr[SECT_LSB-1:0];
  assign r_sect_hit = (burst_addr[ADDR_W-1:SECT_LSB] == sect_reg);
  // write lands at the edge where the master sees pready
  assign apb_wr = PSEL & PENABLE & pready_reg & PWRITE & (PADDR == OFS_CTRL);

  // ----------------------------------------
  // read word selection
  // ----------------------------------------
  always_comb begin
    rd_word = ARR_RDATA;
    if (stat_serve_reg) begin
      rd_word = (beat_reg == '0) ? snap_reg : UNDEF_WORD;
    end else begin
      case (mode_reg)
        MODE_IDCFI: begin
          if (r_sect_hit) begin
            rd_word = ID_WORDS[r_ofs[PW_IDX_W-1:0]*DATA_W +: DATA_W];
          end
        end
        MODE_SECURE: begin
          if (r_sect_hit) begin
            rd_word = (r_ofs < SECT_LSB'(SEC_WORDS)) ? sec_reg[r_ofs[SEC_IDX_W-1:0]]
                                                      : UNDEF_WORD;
          end
        end
        MODE_PROTCFG: rd_word = (burst_addr == ADDR_CFG) ? cfg_reg : UNDEF_WORD;
        MODE_PASSWORD: begin
          rd_word = (burst_addr < ADDR_W'(PW_WORDS)) ? pw_reg[burst_addr[PW_IDX_W-1:0]]
                                                      : UNDEF_WORD;
        end
        default: rd_word = ARR_RDATA;
      endcase
    end
  end

  // ----------------------------------------
  // link sequencing and command decode
  // ----------------------------------------
  always_comb begin
    link_next = link_reg;
    mode_next = mode_reg;
    prev_mode_next = prev_mode_reg;
    sect_next = sect_reg;
    cap_addr_next = cap_addr_reg;
    arr_addr_next = arr_addr_reg;
    beat_next = beat_reg;
    lat_next = lat_reg;
    stat_serve_next = stat_serve_reg;
    snap_next = snap_reg;
    cfg_next = cfg_reg;
    pw_next = pw_reg;
    sec_next = sec_reg;
    prog_arm_next = prog_arm_reg;
    wbuf_cnt_next = wbuf_cnt_reg;
    wbuf_left_next = wbuf_left_reg;
    unlock_act_next = unlock_act_reg;
    unlock_ok_next = unlock_ok_reg;
    unlock_idx_next = unlock_idx_reg;
    lock_next = lock_reg;
    dq_next = dq_reg;
    dq_oe_next = dq_oe_reg;
    read_write_strobe_next = read_write_strobe_reg;
    read_write_strobe_oe_next = read_write_strobe_oe_reg;
    do_write = 1'b0;
    cmd_write = 1'b0;
    read_start = 1'b0;
    beat_fire = 1'b0;
    case (link_reg)
      LNK_IDLE: begin
        dq_oe_next = 1'b0;
        read_write_strobe_oe_next = 1'b0;
        stat_serve_next = 1'b0;
        if (!cs_n_s && ctrl_reg[CTRL_LINK_EN_BIT]) begin
          link_next = LNK_ADDR;
        end
      end
      LNK_ADDR: begin
        if (cs_n_s) begin
          link_next = LNK_IDLE;
        end else if (ck_rise) begin
          cap_addr_next = addr_s;
          if (we_s) begin
            link_next = LNK_WDATA;
          end else begin
            read_start = 1'b1;
            arr_addr_next = addr_s;
            beat_next = '0;
            lat_next = '0;
            dq_oe_next = 1'b1;
            read_write_strobe_oe_next = 1'b1;
            read_write_strobe_next = 1'b0;
            link_next = LNK_LAT;
            if (mode_reg == MODE_STATUS) begin
              stat_serve_next = 1'b1;
              mode_next = prev_mode_reg;
            end
          end
        end
      end
      LNK_WDATA: begin
        if (cs_n_s) begin
          link_next = LNK_IDLE;
        end else if (ck_rise) begin
          do_write = 1'b1;
          link_next = LNK_DONE;
        end
      end
      LNK_LAT: begin
        if (cs_n_s) begin
          link_next = LNK_IDLE;
        end else if (ck_rise) begin
          lat_next = lat_reg + 4'h1;
          if (lat_reg == 4'(LATENCY_CODE - 1)) begin
            link_next = LNK_BURST;
          end
        end
      end
      LNK_BURST: begin
        if (cs_n_s) begin
          link_next = LNK_IDLE;
        end else if (ck_rise) begin
          beat_fire = 1'b1;
          dq_next = rd_word;
          read_write_strobe_next = ~read_write_strobe_reg;
          beat_next = beat_reg + 1'b1;
          arr_addr_next = {cap_addr_reg[ADDR_W-1:BURST_LSB_W],
                           cap_addr_reg[BURST_LSB_W-1:0] + beat_reg + 1'b1};
          if (beat_reg == BURST_LSB_W'(BURST_WORDS - 1)) begin
            link_next = LNK_DONE;
          end
        end
      end
      LNK_DONE: begin
        dq_next = UNDEF_WORD;
        if (cs_n_s) begin
          link_next = LNK_IDLE;
        end
      end
      default: link_next = LNK_IDLE;
    endcase

    if (do_write) begin
      if (unlock_act_reg) begin
        unlock_ok_next = unlock_ok_reg & (dq_s == pw_reg[unlock_idx_reg]);
        unlock_idx_next = unlock_idx_reg + 1'b1;
        if (unlock_idx_reg == PW_IDX_W'(PW_WORDS - 1)) begin
          unlock_act_next = 1'b0;
          if (unlock_ok_next) begin
            lock_next = 1'b0;
          end
        end
      end else if (wbuf_cnt_reg) begin
        wbuf_cnt_next = 1'b0;
        wbuf_left_next = {1'b0, dq_s[WBUF_CNT_W-1:0]} + 1'b1;
      end else if (prog_arm_reg || wbuf_left_reg != '0) begin
        prog_arm_next = 1'b0;
        if (wbuf_left_reg != '0) begin
          wbuf_left_next = wbuf_left_reg - 1'b1;
        end
        if (mode_reg == MODE_SECURE && w_sect_hit && w_ofs < SECT_LSB'(SEC_WORDS)) begin
          sec_next[w_ofs[SEC_IDX_W-1:0]] = sec_reg[w_ofs[SEC_IDX_W-1:0]] & dq_s;
        end
        if (mode_reg == MODE_PROTCFG && cap_addr_reg == ADDR_CFG) begin
          cfg_next = cfg_reg & dq_s;
        end
        if (mode_reg == MODE_PASSWORD && cap_addr_reg < ADDR_W'(PW_WORDS)) begin
          pw_next[cap_addr_reg[PW_IDX_W-1:0]] = pw_reg[cap_addr_reg[PW_IDX_W-1:0]] & dq_s;
        end
      end else begin
        cmd_write = 1'b1;
        if (cap_addr_reg == ADDR_EXIT && dq_s == CMD_EXIT) begin
          mode_next = MODE_ARRAY;
        end else if (dq_s == CMD_LEGACY_EXIT && (mode_reg == MODE_SECURE ||
                     mode_reg == MODE_PROTCFG || mode_reg == MODE_PASSWORD)) begin
          mode_next = MODE_ARRAY;
        end else if (dq_s == CMD_STATUS) begin
          snap_next = STAT_IN;
          if (mode_reg != MODE_STATUS) begin
            prev_mode_next = mode_reg;
          end
          mode_next = MODE_STATUS;
        end else if (dq_s == CMD_PROGRAM) begin
          prog_arm_next = 1'b1;
        end else if (dq_s == CMD_WBUF && mode_reg == MODE_SECURE) begin
          wbuf_cnt_next = 1'b1;
        end else if (dq_s == CMD_UNLOCK && mode_reg == MODE_PASSWORD) begin
          unlock_act_next = 1'b1;
          unlock_ok_next = 1'b1;
          unlock_idx_next = '0;
        end else if (mode_reg == MODE_ARRAY && w_ofs == OFS_CMD) begin
          if (dq_s == CMD_ID_ENTRY) begin
            mode_next = MODE_IDCFI;
            sect_next = cap_addr_reg[ADDR_W-1:SECT_LSB];
          end else if (dq_s == CMD_SECURE_ENTRY) begin
            mode_next = MODE_SECURE;
            sect_next = cap_addr_reg[ADDR_W-1:SECT_LSB];
          end else if (dq_s == CMD_PROTCFG_ENTRY) begin
            mode_next = MODE_PROTCFG;
          end else if (dq_s == CMD_PASSWORD_ENTRY) begin
            mode_next = MODE_PASSWORD;
          end
        end
      end
    end
    // lock set by software wins over a same-cycle unlock
    if (apb_wr && PWDATA[CTRL_LOCK_SET_BIT]) begin
      lock_next = 1'b1;
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  always_comb begin
    pready_next = PSEL & PENABLE & ~pready_reg;
    prdata_next = 32'h0000_0000;
    pslverr_next = 1'b0;
    ctrl_next = ctrl_reg;
    crc_next = CRC_LOAD ? CRC_RESULT : crc_reg;
    if (apb_wr) begin
      ctrl_next = {31'h0000_0000, PWDATA[CTRL_LINK_EN_BIT]};
    end
    if (pready_next) begin
      case (PADDR)
        OFS_CRC_LOW: prdata_next = {16'h0000, crc_reg[15:0]};
        OFS_CRC_HIGH: prdata_next = {16'h0000, crc_reg[31:16]};
        OFS_CTRL: prdata_next = ctrl_reg;
        OFS_STATUS: begin
          prdata_next[ST_MODE_LSB +: 6] = mode_reg;
          prdata_next[ST_LOCK_BIT] = lock_reg;
          prdata_next[ST_SECT_LSB +: SECT_W] = sect_reg;
        end
        default: pslverr_next = 1'b1;
      endcase
      if (PWRITE) begin
        prdata_next = 32'h0000_0000;
        pslverr_next = (PADDR != OFS_CTRL);
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      link_reg <= LNK_IDLE;
      mode_reg <= MODE_ARRAY;
      prev_mode_reg <= MODE_ARRAY;
      sect_reg <= '0;
      cap_addr_reg <= '0;
      arr_addr_reg <= '0;
      beat_reg <= '0;
      lat_reg <= '0;
      stat_serve_reg <= 1'b0;
      snap_reg <= '0;
      cfg_reg <= PROTCFG_RESET;
      for (int i = 0; i < PW_WORDS; i++) begin
        pw_reg[i] <= PASSWORD_RESET[i*DATA_W +: DATA_W];
      end
      for (int i = 0; i < SEC_WORDS; i++) begin
        sec_reg[i] <= '1;
      end
      prog_arm_reg <= 1'b0;
      wbuf_cnt_reg <= 1'b0;
      wbuf_left_reg <= '0;
      unlock_act_reg <= 1'b0;
      unlock_ok_reg <= 1'b0;
      unlock_idx_reg <= '0;
      lock_reg <= 1'b1;
      dq_reg <= '0;
      dq_oe_reg <= 1'b0;
      read_write_strobe_reg <= 1'b0;
      read_write_strobe_oe_reg <= 1'b0;
      ctrl_reg <= CTRL_RESET;
      crc_reg <= CRC_RESET;
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      link_reg <= link_next;
      mode_reg <= mode_next;
      prev_mode_reg <= prev_mode_next;
      sect_reg <= sect_next;
      cap_addr_reg <= cap_addr_next;
      arr_addr_reg <= arr_addr_next;
      beat_reg <= beat_next;
      lat_reg <= lat_next;
      stat_serve_reg <= stat_serve_next;
      snap_reg <= snap_next;
      cfg_reg <= cfg_next;
      pw_reg <= pw_next;
      sec_reg <= sec_next;
      prog_arm_reg <= prog_arm_next;
      wbuf_cnt_reg <= wbuf_cnt_next;
      wbuf_left_reg <= wbuf_left_next;
      unlock_act_reg <= unlock_act_next;
      unlock_ok_reg <= unlock_ok_next;
      unlock_idx_reg <= unlock_idx_next;
      lock_reg <= lock_next;
      dq_reg <= dq_next;
      dq_oe_reg <= dq_oe_next;
      read_write_strobe_reg <= read_write_strobe_next;
      read_write_strobe_oe_reg <= read_write_strobe_oe_next;
      ctrl_reg <= ctrl_next;
      crc_reg <= crc_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign LINK_DQ_O = dq_reg;
  assign LINK_DQ_OE = dq_oe_reg;
  assign LINK_READ_WRITE_STROBE_O = read_write_strobe_reg;
  assign LINK_READ_WRITE_STROBE_OE = read_write_strobe_oe_reg;
  assign ARR_ADDR = arr_addr_reg;
  assign GLOBAL_LOCK = lock_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  // read data was formed one edge before pready shows
  logic [15:0] crc_high;
  assign crc_high = crc_reg[31:16];

  AST_CRC_HOLD: assert property (CRC_LOAD |=> crc_reg == $past(CRC_RESULT))
    else $error("check-value not captured");
  AST_CRC_SPLIT: assert property (PREADY && !PWRITE && PADDR == OFS_CRC_HIGH
    |-> PRDATA == {16'h0000, $past(crc_high)})
    else $error("high word mismatch");
  AST_ID_ENTRY: assert property (cmd_write && mode_reg == MODE_ARRAY
    && w_ofs == OFS_CMD && dq_s == CMD_ID_ENTRY
    |=> mode_reg == MODE_IDCFI && sect_reg == $past(cap_addr_reg[ADDR_W-1:SECT_LSB]))
    else $error("id entry failed");
  AST_EXIT: assert property (cmd_write && cap_addr_reg == ADDR_EXIT && dq_s == CMD_EXIT
    |=> mode_reg == MODE_ARRAY)
    else $error("common exit failed");
  AST_STATUS_SNAP: assert property (cmd_write && dq_s == CMD_STATUS
    |=> mode_reg == MODE_STATUS && snap_reg == $past(STAT_IN))
    else $error("status not captured");
  AST_STATUS_EXIT: assert property (read_start && mode_reg == MODE_STATUS
    |=> mode_reg == $past(prev_mode_reg) && stat_serve_reg)
    else $error("status overlay not left");
  AST_STATUS_FIRST: assert property (beat_fire && stat_serve_reg && beat_reg == '0
    |=> LINK_DQ_O == $past(snap_reg))
    else $error("status word missing");
  AST_SECURE_KEEP: assert property (read_start && mode_reg == MODE_SECURE
    |=> mode_reg == MODE_SECURE)
    else $error("read ended secure overlay");
  AST_WRAP: assert property (beat_fire
    |=> ARR_ADDR[ADDR_W-1:BURST_LSB_W] == cap_addr_reg[ADDR_W-1:BURST_LSB_W])
    else $error("burst left its group");
  AST_NO_TOGGLE: assert property (link_reg == LNK_LAT || link_reg == LNK_DONE
    |=> $stable(LINK_READ_WRITE_STROBE_O))
    else $error("strobe toggled while idle");
  AST_ONE_MODE: assert property ($onehot(mode_reg))
    else $error("more than one overlay");

  COV_ID: cover property (cmd_write && dq_s == CMD_ID_ENTRY ##1 mode_reg == MODE_IDCFI);
  COV_STATUS: cover property (stat_serve_reg && beat_fire);
  COV_BURST_END: cover property (beat_fire && link_next == LNK_DONE);
  COV_UNLOCK: cover property ($fell(lock_reg));

endmodule

// file: flash_host_model.sv
// host controller model driving link frames
module flash_host_model
  import flash_overlay_pkg::*;
(
  input wire logic clk,
  input wire logic [DATA_W-1:0] dq_o,
  input wire logic strobe,
  input wire logic oe,
  output logic ck = 1'b0,
  output logic cs_n = 1'b1,
  output logic we = 1'b0,
  output logic [ADDR_W-1:0] addr = '0,
  output logic [DATA_W-1:0] dq_i = '0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic seen = 1'b0;
  logic oe_seen = 1'b0;
  logic [DATA_W-1:0] got[$];
  // one word per strobe change; the change as the bus turns round is no word
  always @(posedge clk) begin
    seen <= strobe;
    oe_seen <= oe;
    if (strobe !== seen && oe && oe_seen) got.push_back(dq_o);
  end
  // link clock stands still outside frames
  task automatic frame(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input int n);
    @(posedge clk);
    cs_n <= 1'b0;
    we <= w;
    addr <= a;
    dq_i <= d;
    got.delete();
    repeat (n) begin
      repeat (4) @(posedge clk);
      ck <= 1'b1;
      repeat (4) @(posedge clk);
      ck <= 1'b0;
    end
    repeat (6) @(posedge clk);
    cs_n <= 1'b1;
    addr <= ~a;
    dq_i <= ~d;
    repeat (8) @(posedge clk);
  endtask
endmodule

// file: flash_overlay_space_select_bench.sv
// bench of the overlay space selector
module flash_overlay_space_select_bench
  import flash_overlay_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // arbitrary identification words
  localparam logic [63:0] IDW = 64'h0004_0003_0002_0001;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, ld = 1'b0;
  logic rdy, err, slv, ck, cs_n, we, lock, stb, doe, roe;
  logic [APB_AW-1:0] pa = '0;
  logic [31:0] pw = '0, prd, rdv, crc = '0, seed = 32'h0000_004B;
  logic [ADDR_W-1:0] la, aa;
  logic [DATA_W-1:0] di, dq, ad = '0, stat = '0;
  logic [DATA_W-1:0] codes[4] = '{CMD_ID_ENTRY, CMD_SECURE_ENTRY, CMD_PROTCFG_ENTRY,
                                 CMD_PASSWORD_ENTRY};
  mode_e modes[4] = '{MODE_IDCFI, MODE_SECURE, MODE_PROTCFG, MODE_PASSWORD};
  logic [7:0] s;
  int failures = 0, n_tests = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) ad <= aa[15:0] ^ 16'hA5A5;
  flash_overlay_space_select #(.ID_WORDS(IDW)) u_dut (.REF_CLK(clk), .RSTN(rst_n),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pw), .PRDATA(prd),
    .PREADY(rdy), .PSLVERR(slv), .LINK_CK(ck), .LINK_CS_N(cs_n), .LINK_WE(we),
    .LINK_ADDR(la), .LINK_DQ_I(di), .LINK_DQ_O(dq), .LINK_DQ_OE(doe), .LINK_READ_WRITE_STROBE_O(stb),
    .LINK_READ_WRITE_STROBE_OE(roe), .ARR_ADDR(aa), .ARR_RDATA(ad), .STAT_IN(stat), .CRC_RESULT(crc),
    .CRC_LOAD(ld), .GLOBAL_LOCK(lock));
  flash_host_model u_host (.clk(clk), .dq_o(dq), .strobe(stb), .oe(doe & roe), .ck(ck),
    .cs_n(cs_n), .we(we), .addr(la), .dq_i(di));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [APB_AW-1:0] a);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    @(posedge clk);
    pen <= 1'b1;
    // pready ends this wait; the watchdog covers a hang
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    rdv = prd;
    err = slv;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic mode(input logic [5:0] m);
    apb(1'b0, OFS_STATUS);
    chk("mode", rdv[5:0], m);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("lock", lock, 1);
    apb(1'b0, OFS_CTRL);
    chk("ctrl", rdv, CTRL_RESET);
    apb(1'b0, 12'h010);
    chk("unmapped", err, 1);
    apb(1'b1, OFS_CRC_LOW);
    chk("ro", err, 1);
    repeat (3) begin
      seed = xs(seed);
      crc <= seed;
      ld <= 1'b1;
      @(posedge clk);
      ld <= 1'b0;
      apb(1'b0, OFS_CRC_LOW);
      chk("crc lo", rdv, {16'h0000, seed[15:0]});
      apb(1'b0, OFS_CRC_HIGH);
      chk("crc hi", rdv, {16'h0000, seed[31:16]});
    end
    s = seed[7:0];
    foreach (codes[i]) begin
      u_host.frame(1'b1, {s, OFS_CMD}, codes[i], 2);
      mode(modes[i]);
      u_host.frame(1'b1, ADDR_EXIT, i[0] ? CMD_LEGACY_EXIT : CMD_EXIT, 2);
      mode(MODE_ARRAY);
    end
    u_host.frame(1'b1, {s, OFS_CMD}, CMD_ID_ENTRY, 2);
    u_host.frame(1'b0, {s, 16'h0001}, '0, 14);
    chk("id", u_host.got[0], IDW[31:16]);
    u_host.frame(1'b0, {s + 8'h01, 16'h0040}, '0, 14);
    chk("array", u_host.got[0], 16'h0040 ^ 16'hA5A5);
    u_host.frame(1'b1, ADDR_EXIT, CMD_EXIT, 2);
    stat <= seed[31:16];
    u_host.frame(1'b1, 24'h00_0555, CMD_STATUS, 2);
    u_host.frame(1'b0, 24'h00_0040, '0, 14);
    chk("status", u_host.got[0], seed[31:16]);
    mode(MODE_ARRAY);
    u_host.frame(1'b1, 24'h00_0555, CMD_PASSWORD_ENTRY, 2);
    u_host.frame(1'b0, ADDR_CFG, '0, 18);
    for (int k = 0; k < 5; k++) chk("pw", u_host.got[k], k < 4 ? 16'hFFFF : UNDEF_WORD);
    u_host.frame(1'b1, ADDR_CFG, CMD_UNLOCK, 2);
    repeat (4) u_host.frame(1'b1, ADDR_CFG, 16'hFFFF, 2);
    chk("unlock", lock, 0);
    u_host.frame(1'b1, ADDR_EXIT, CMD_EXIT, 2);
    pw <= 32'h0000_0002;
    apb(1'b1, OFS_CTRL);
    chk("lock set", lock, 1);
    u_host.frame(1'b1, {s, OFS_CMD}, CMD_ID_ENTRY, 2);
    mode(MODE_ARRAY);
    pw <= 32'h0000_0001;
    apb(1'b1, OFS_CTRL);
    u_host.frame(1'b1, {s, OFS_CMD}, CMD_SECURE_ENTRY, 2);
    u_host.frame(1'b1, {s, OFS_CMD}, CMD_PROGRAM, 2);
    u_host.frame(1'b1, {s, 16'h0001}, seed[31:16], 2);
    u_host.frame(1'b1, {s, OFS_CMD}, CMD_WBUF, 2);
    u_host.frame(1'b1, {s, OFS_CMD}, 16'h0000, 2);
    u_host.frame(1'b1, {s, 16'h0000}, 16'h0F0F, 2);
    u_host.frame(1'b0, {s, 16'h001F}, '0, 17);
    chk("sec undef", u_host.got[0], UNDEF_WORD);
    chk("sec wbuf", u_host.got[1], 16'h0F0F);
    chk("sec word", u_host.got[2], seed[31:16]);
    chk("sec blank", u_host.got[3], 16'hFFFF);
    u_host.frame(1'b0, {s + 8'h01, 16'h0040}, '0, 14);
    chk("sec other", u_host.got[0], 16'h0040 ^ 16'hA5A5);
    mode(MODE_SECURE);
    u_host.frame(1'b1, ADDR_EXIT, CMD_EXIT, 2);
    u_host.frame(1'b1, {s, OFS_CMD}, CMD_PROTCFG_ENTRY, 2);
    u_host.frame(1'b1, ADDR_EXIT, CMD_PROGRAM, 2);
    u_host.frame(1'b1, ADDR_CFG, 16'hFF0F, 2);
    u_host.frame(1'b0, ADDR_CFG, '0, 15);
    chk("cfg", u_host.got[0], 16'hFF0F);
    chk("cfg undef", u_host.got[1], UNDEF_WORD);
    u_host.frame(1'b1, ADDR_EXIT, CMD_LEGACY_EXIT, 2);
    mode(MODE_ARRAY);
    seed = xs(seed);
    u_host.frame(1'b0, seed[23:0], '0, 47);
    chk("beats", u_host.got.size(), 32);
    for (int k = 0; k < 32; k++) chk("beat", u_host.got[k],
      {seed[15:5], seed[4:0] + 5'(k)} ^ 16'hA5A5);
    end_of_test();
  end
endmodule
